//--- rtl/tc_timer_params.svh
// constants for the eight/sixteen bit timer counter
`ifndef TC_TIMER_PARAMS_SVH
`define TC_TIMER_PARAMS_SVH

// ****************************************
// clock source select encodings
// ****************************************
`define TC_SRC_CPU_CLK      2'h0
`define TC_SRC_INSTR_CYC    2'h1
`define TC_SRC_EXT_BIT      1

// ****************************************
// timing and reset values
// ****************************************
`define TC_INSTR_DIV        4
`define TC_DIV_W            2
`define TC_DIV_LAST         2'h3
`define TC_COUNT_RST        16'h0000
`define TC_BYTE_RST         8'h00
`define TC_MAX_8            8'hFF
`define TC_MAX_16           16'hFFFF

`endif

//--- rtl/tc_timer_pkg.sv
// types for the eight/sixteen bit timer counter
package tc_timer_pkg;

    // ****************************************
    // control fields held by software
    // ****************************************
    typedef struct packed {
        logic       width_select_bit;
        logic [1:0] count_source_select;
        logic       edge_falling;
        logic       timer_on;
    } tc_ctrl_t;

    // ****************************************
    // byte access strobes from the cpu side
    // ****************************************
    typedef struct packed {
        logic       low_rd;
        logic       low_wr;
        logic       high_wr;
        logic [7:0] wr_data;
    } tc_access_t;

    typedef enum logic [1:0] {
        TC_MODE_CPU,
        TC_MODE_INSTR,
        TC_MODE_EXT
    } tc_mode_t;

endpackage

//--- rtl/tc_tick.sv
// count tick generator for the timer counter
`timescale 1ns/100ps
`include "tc_timer_params.svh"

module tc_tick (
    input  wire logic                    ref_clk,
    input  wire logic                    reset,
    input  wire tc_timer_pkg::tc_ctrl_t  ctrl,
    input  wire logic                    external_count_input,
    output logic                         tick
);

    logic [`TC_DIV_W-1:0]  nxt_div;
    logic [`TC_DIV_W-1:0]  div_cnt_ff;
    logic                  pin_ff;
    logic                  tick_ff;
    logic                  nxt_tick;
    tc_timer_pkg::tc_mode_t mode;

    always_comb begin
        if (ctrl.count_source_select[`TC_SRC_EXT_BIT]) begin
            mode = tc_timer_pkg::TC_MODE_EXT;
        end else if (ctrl.count_source_select == `TC_SRC_INSTR_CYC) begin
            mode = tc_timer_pkg::TC_MODE_INSTR;
        end else begin
            mode = tc_timer_pkg::TC_MODE_CPU;
        end
    end

    always_comb begin
        nxt_div = div_cnt_ff + {{(`TC_DIV_W-1){1'b0}}, 1'b1};
        case (mode)
            tc_timer_pkg::TC_MODE_CPU: begin
                nxt_tick = ctrl.timer_on;
            end
            tc_timer_pkg::TC_MODE_INSTR: begin
                nxt_tick = ctrl.timer_on && (div_cnt_ff == `TC_DIV_LAST);
            end
            tc_timer_pkg::TC_MODE_EXT: begin
                // rising or falling edge of the pin
                nxt_tick = ctrl.timer_on && (ctrl.edge_falling ? (pin_ff && !external_count_input)
                                                               : (!pin_ff && external_count_input));
            end
            default: begin
                nxt_tick = 1'b0;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            div_cnt_ff <= {`TC_DIV_W{1'b0}};
            pin_ff     <= 1'b0;
            tick_ff    <= 1'b0;
        end else begin
            div_cnt_ff <= nxt_div;
            pin_ff     <= external_count_input;
            tick_ff    <= nxt_tick;
        end
    end

    assign tick = tick_ff;

endmodule // tc_tick

//--- rtl/tc_timer.sv
// eight/sixteen bit timer counter top
`timescale 1ns/100ps
`include "tc_timer_params.svh"

module tc_timer (
    input  wire logic                    ref_clk,
    input  wire logic                    reset,
    input  wire tc_timer_pkg::tc_ctrl_t  ctrl,
    input  wire tc_timer_pkg::tc_access_t acc,
    input  wire logic                    external_count_input,
    input  wire logic                    ovf_clr,
    output logic [7:0]                   low_byte_register,
    output logic [7:0]                   high_byte_buffer,
    output logic                         overflow_flag
);

    logic        tick;
    logic        step;
    logic        wrap_8;
    logic        wrap_16;
    logic        wrap;
    logic [15:0] count_ff;
    logic [15:0] nxt_count;
    logic [7:0]  buf_ff;
    logic [7:0]  nxt_buf;
    logic        ovf_ff;
    logic        nxt_ovf;

    tc_tick u_tick (
        .ref_clk              (ref_clk),
        .reset                (reset),
        .ctrl                 (ctrl),
        .external_count_input (external_count_input),
        .tick                 (tick)
    );

    // ****************************************
    // step and wrap qualification
    // ****************************************
    // a low byte write swallows a tick in the same cycle
    always_comb begin
        step    = tick && !acc.low_wr;
        wrap_8  = (count_ff[7:0] == `TC_MAX_8);
        wrap_16 = (count_ff == `TC_MAX_16);
        if (ctrl.width_select_bit) begin
            wrap = step && wrap_8;
        end else begin
            wrap = step && wrap_16;
        end
    end

    // ****************************************
    // counter next state
    // ****************************************
    always_comb begin
        nxt_count = count_ff;
        if (acc.low_wr) begin
            if (ctrl.width_select_bit) begin
                // high byte frozen while in 8-bit mode
                nxt_count = {count_ff[15:8], acc.wr_data};
            end else begin
                // both halves land in one edge
                nxt_count = {buf_ff, acc.wr_data};
            end
        end else if (step) begin
            if (ctrl.width_select_bit) begin
                nxt_count = {count_ff[15:8], count_ff[7:0] + 8'h01};
            end else begin
                nxt_count = count_ff + 16'h0001;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            count_ff <= `TC_COUNT_RST;
        end else begin
            count_ff <= nxt_count;
        end
    end

    // ****************************************
    // high byte buffer next state
    // ****************************************
    // a buffer write beats the read copy in the same cycle
    always_comb begin
        nxt_buf = buf_ff;
        if (acc.high_wr) begin
            nxt_buf = acc.wr_data;
        end else if (acc.low_rd && !ctrl.width_select_bit) begin
            // snapshot of the real high byte
            nxt_buf = count_ff[15:8];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            buf_ff <= `TC_BYTE_RST;
        end else begin
            buf_ff <= nxt_buf;
        end
    end

    // ****************************************
    // overflow flag next state
    // ****************************************
    always_comb begin
        // set wins over clear
        nxt_ovf = wrap | (ovf_ff & ~ovf_clr);
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            ovf_ff <= 1'b0;
        end else begin
            ovf_ff <= nxt_ovf;
        end
    end

    // ****************************************
    // outputs, each straight from a register
    // ****************************************

    assign low_byte_register = count_ff[7:0];
    assign high_byte_buffer  = buf_ff;
    assign overflow_flag     = ovf_ff;

endmodule // tc_timer

//--- testbench/tc_timer_sva.sv
// assertions for the timer counter
`timescale 1ns/100ps
module tc_timer_sva (
    input wire logic ref_clk,
    input wire logic reset,
    input wire tc_timer_pkg::tc_ctrl_t ctrl,
    input wire tc_timer_pkg::tc_access_t acc,
    input wire logic external_count_input,
    input wire logic ovf_clr,
    input wire logic [7:0] low_byte_register,
    input wire logic [7:0] high_byte_buffer,
    input wire logic overflow_flag
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);
    low_write_a: assert property (acc.low_wr |=> low_byte_register == $past(acc.wr_data))
        else $error("low write");
    buf_write_a: assert property (acc.high_wr |=> high_byte_buffer == $past(acc.wr_data))
        else $error("buffer write");
    cpu_step_a: assert property ((ctrl.timer_on && ctrl.count_source_select == 2'h0 && !acc.low_wr)[*2]
        |=> low_byte_register == $past(low_byte_register) + 8'h01) else $error("cpu step");
    instr_gap_a: assert property (!$past(reset) && ctrl.count_source_select == 2'h1 && !$past(acc.low_wr)
        && $changed(low_byte_register) |=> $stable(low_byte_register)[*3]) else $error("instr gap");
    ext_idle_a: assert property ((ctrl.count_source_select[1] && !acc.low_wr
        && $stable(external_count_input))[*4] |=> $stable(low_byte_register)) else $error("ext idle");
    buf_cause_a: assert property (!$past(reset) && $changed(high_byte_buffer) |-> $past(acc.high_wr)
        || ($past(acc.low_rd) && !$past(ctrl.width_select_bit))) else $error("buffer cause");
    wrap_zero_a: assert property ($rose(overflow_flag) |-> low_byte_register == 8'h00)
        else $error("wrap flag");
    c_wrap: cover property ($rose(overflow_flag));
    c_read: cover property (acc.low_rd && !ctrl.width_select_bit);
    c_ext: cover property (ctrl.count_source_select[1] && $changed(low_byte_register));
endmodule // tc_timer_sva
bind tc_timer tc_timer_sva u_sva (.*);

//--- testbench/tc_ext_src.sv
// external edge source model for the timer counter
`timescale 1ns/100ps
module tc_ext_src (
    input wire logic ref_clk,
    input wire logic start,
    input wire logic [7:0] n,
    input wire logic slow,
    output logic pin,
    output logic busy
);
    int left = 0;
    int gap = 0;
    initial pin = 1'b0;
    assign busy = left > 0;
    always @(posedge ref_clk) begin
        if (start)
            left <= 2 * n;
        else if (gap > 0)
            gap <= gap - 1;
        else if (left > 0) begin
            pin <= ~pin;
            left <= left - 1;
            gap <= slow ? 3 : 0;
        end
    end
endmodule // tc_ext_src

//--- testbench/tb_tc_timer.sv
// self-checking bench for the timer counter
`timescale 1ns/100ps
`define CMP(s,x,y) begin n_compared++; if ((x)!==(y)) begin mismatches++; $display("FAIL %s exp %h got %h",s,x,y); end end
module tb_tc_timer;
    logic ref_clk = 1'b0, reset = 1'b1, ovf_clr = 1'b0, start = 1'b0, slow = 1'b0, pin, busy, flag;
    tc_timer_pkg::tc_ctrl_t ctrl = '0;
    tc_timer_pkg::tc_access_t acc = '0;
    logic [7:0] low, hb, n = 8'h00;
    logic [15:0] r;
    logic [9:0] q[$], e;
    int mismatches, n_compared, cycles;
    tc_timer uut (.ref_clk(ref_clk), .reset(reset), .ctrl(ctrl), .acc(acc), .external_count_input(pin),
        .ovf_clr(ovf_clr), .low_byte_register(low), .high_byte_buffer(hb), .overflow_flag(flag));
    tc_ext_src src (.ref_clk(ref_clk), .start(start), .n(n), .slow(slow), .pin(pin), .busy(busy));
    always #2.5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 2000) begin
            mismatches++;
            results();
        end
        if (q.size() > 0) begin
            e = q.pop_front();
            `CMP(e[9:8] == 2'h0 ? "low_byte_register" : e[9:8] == 2'h1 ? "high_byte_buffer" : "overflow_flag",
                e[7:0], e[9:8] == 2'h0 ? low : e[9:8] == 2'h1 ? hb : {7'h00, flag})
        end
    end
    task cyc(input logic [10:0] a);
        acc = a;
        @(negedge ref_clk);
    endtask
    task chk(input logic [9:0] v);
        q.push_back(v);
        @(negedge ref_clk);
    endtask
    task rd;
        cyc(11'h400);
        cyc(11'h000);
    endtask
    task wr16(input logic [15:0] v);
        cyc({3'h1, v[15:8]});
        cyc({3'h2, v[7:0]});
        cyc(11'h000);
    endtask
    // count until the wrap, then stop
    task run(input logic [4:0] c);
        ctrl = c;
        for (int i = 0; i < 600 && flag !== 1'b1; i++)
            @(negedge ref_clk);
        ctrl = c & 5'h1E;
    endtask
    task results;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        void'($urandom(32'h6164));
        repeat (3) @(negedge ref_clk);
        reset = 1'b0;
        r = 16'($urandom);
        wr16(r);
        cyc(11'h1A5);
        rd;
        chk({2'h0, r[7:0]});
        chk({2'h1, r[15:8]});
        $display("test rw done");
        wr16(16'hFFFE);
        run(5'h01);
        chk({2'h2, 8'h01});
        rd;
        chk({2'h0, 8'h01});
        chk({2'h1, 8'h00});
        ovf_clr = 1'b1;
        cyc(11'h15A);
        ovf_clr = 1'b0;
        chk({2'h2, 8'h00});
        ctrl = 5'h10;
        cyc(11'h2FE);
        cyc(11'h000);
        run(5'h11);
        rd;
        chk({2'h0, 8'h01});
        chk({2'h1, 8'h5A});
        $display("test wrap done");
        wr16(16'h0000);
        ctrl = 5'h05;
        repeat (40) @(negedge ref_clk);
        ctrl = 5'h00;
        rd;
        chk({2'h0, 8'h0A});
        chk({2'h1, 8'h00});
        $display("test instr done");
        for (int k = 0; k < 2; k++) begin
            wr16(16'h0000);
            n = 8'($urandom_range(20, 1));
            slow = k[0];
            ctrl = {k[0], 1'b1, 1'($urandom), k[0], 1'b1};
            start = 1'b1;
            @(negedge ref_clk);
            start = 1'b0;
            for (int i = 0; i < 200 && busy; i++)
                @(negedge ref_clk);
            repeat (4) @(negedge ref_clk);
            ctrl = 5'h00;
            rd;
            chk({2'h0, n});
            chk({2'h1, 8'h00});
            $display("test ext %0d done", k);
        end
        results();
    end
endmodule // tb_tc_timer
